// [rtl/dma_notify_pkg.sv]
// shared constants for the dma doorbell completion notify block
package dma_notify_pkg;
   // completion status codes returned for configuration requests
   localparam logic [2:0] CPL_SUCCESS = 3'h0;
   localparam logic [2:0] CPL_RETRY = 3'h2;
   // run/busy/done bit positions of dma_channel_status_reg
   localparam int STS_RUN_BIT = 0;
   localparam int STS_BUSY_BIT = 1;
   localparam int STS_DONE_BIT = 2;
   localparam int STS_W = 3;
   localparam logic [STS_W-1:0] STS_RESET = 3'h0;
   // offsets inside the nt configuration window mapped at bar 0
   localparam logic [11:0] RING_SET_OFF = 12'h0A0;
   localparam logic [11:0] MSG_OFF = 12'h0C0;
   localparam int NT_WIN_BITS = 12;
   // low bar bits that hold memory type flags, not address
   localparam int BAR_FLAG_BITS = 4;
   // host setup deadline after fundamental reset
   localparam int SETUP_LIMIT_MS = 1000;
   localparam int CLK_HZ = 40000000;
   localparam int SETUP_CYCLES = (CLK_HZ / 1000) * SETUP_LIMIT_MS;
   typedef enum logic [5:0] {
      ST_IDLE = 6'h01,
      ST_FETCH = 6'h02,
      ST_ISSUE = 6'h04,
      ST_IMM_WAIT = 6'h08,
      ST_DRAIN = 6'h10,
      ST_DONE = 6'h20
   } dma_state_t;
endpackage : dma_notify_pkg

// [rtl/write_skid_buffer.sv]
// two-entry buffer with valid/ready on both sides, outputs from flops
`timescale 1ns/100ps
module write_skid_buffer #(
   parameter int WIDTH = 96
) (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   logic [WIDTH-1:0] head_ff, nxt_head, tail_ff, nxt_tail;
   logic head_v_ff, nxt_head_v, tail_v_ff, nxt_tail_v;

   initial begin
      if (WIDTH < 1) $error("write_skid_buffer: WIDTH must be positive");
   end

   assign in_ready = !tail_v_ff;
   assign out_valid = head_v_ff;
   assign out_data = head_ff;

   always_comb begin
      nxt_head = head_ff;
      nxt_head_v = head_v_ff;
      nxt_tail = tail_ff;
      nxt_tail_v = tail_v_ff;
      if (head_v_ff && out_ready) begin
         if (tail_v_ff) begin
            nxt_head = tail_ff;
            nxt_tail_v = 1'b0;
         end else begin
            nxt_head_v = 1'b0;
         end
      end
      if (in_valid && !tail_v_ff) begin
         if (!nxt_head_v) begin
            nxt_head = in_data;
            nxt_head_v = 1'b1;
         end else begin
            nxt_tail = in_data;
            nxt_tail_v = 1'b1;
         end
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         head_ff <= '0;
         tail_ff <= '0;
         head_v_ff <= 1'b0;
         tail_v_ff <= 1'b0;
      end else begin
         head_ff <= nxt_head;
         tail_ff <= nxt_tail;
         head_v_ff <= nxt_head_v;
         tail_v_ff <= nxt_tail_v;
      end
   end
endmodule : write_skid_buffer

// [rtl/ring_crossmap.sv]
// outbound ring and message delivery into the peer partition
`timescale 1ns/100ps
module ring_crossmap #(
   parameter int RING_BITS = 32,
   parameter int IDX_W = 5
) (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic set_valid,
   input wire logic [RING_BITS-1:0] set_mask,
   input wire logic [RING_BITS*IDX_W-1:0] ring_map,
   input wire logic [RING_BITS-1:0] peer_clear,
   input wire logic msg_valid,
   input wire logic [31:0] msg_data,
   input wire logic peer_msg_taken,
   output logic [RING_BITS-1:0] peer_ring_ff,
   output logic peer_intr_ff,
   output logic [31:0] peer_msg_ff,
   output logic peer_msg_full_ff
);
   logic [RING_BITS-1:0] nxt_peer_ring, map_set;
   logic nxt_peer_intr, nxt_msg_full;
   logic [31:0] nxt_msg;

   initial begin
      if ((1 << IDX_W) < RING_BITS) $error("ring_crossmap: IDX_W too small");
   end

   always_comb begin
      map_set = '0;
      for (int i = 0; i < RING_BITS; i++) begin
         if (set_valid && set_mask[i])
            map_set[ring_map[i*IDX_W +: IDX_W]] = 1'b1;
      end
      // a set in the same cycle as the peer's clear wins
      nxt_peer_ring = (peer_ring_ff & ~peer_clear) | map_set;
      nxt_peer_intr = |(map_set & ~peer_ring_ff) || msg_valid;
      nxt_msg = msg_valid ? msg_data : peer_msg_ff;
      nxt_msg_full = msg_valid || (peer_msg_full_ff && !peer_msg_taken);
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         peer_ring_ff <= '0;
         peer_intr_ff <= 1'b0;
         peer_msg_ff <= '0;
         peer_msg_full_ff <= 1'b0;
      end else begin
         peer_ring_ff <= nxt_peer_ring;
         peer_intr_ff <= nxt_peer_intr;
         peer_msg_ff <= nxt_msg;
         peer_msg_full_ff <= nxt_msg_full;
      end
   end
endmodule : ring_crossmap

// [rtl/dma_doorbell_completion_notify.sv]
// dma channel with immediate descriptors and nt doorbell notification
// Functional notes
// - unattached ports answer config with retry
// - dma bars 0/1 pair to 64-bit base
// - run bit starts descriptor list processing
// - immediate descriptor writes its data to address
// - transfer completion raises msi or legacy interrupt
// - nt config window at bar 0 takes writes
// - outbound ring bit sets mapped peer inbound bit
// - new inbound bit interrupts the peer root
// - message write notifies peer and delivers content
`timescale 1ns/100ps
module dma_doorbell_completion_notify #(
   parameter int RING_BITS = 32,
   parameter int IDX_W = 5,
   parameter int OUTST_W = 4,
   parameter int SETUP_CYCLES = dma_notify_pkg::SETUP_CYCLES
) (
   input wire logic ref_clk,
   input wire logic rst_n,
   // configuration requests from the partition root
   input wire logic unattached_mode,
   input wire logic cfg_req_valid,
   output logic cfg_cpl_valid_ff,
   output logic [2:0] cfg_cpl_status_ff,
   output logic setup_late_ff,
   // dma function bars
   input wire logic bar_pair_64,
   input wire logic [31:0] dma_bar0,
   input wire logic [31:0] dma_bar1,
   output logic [63:0] dma_cfg_base_ff,
   // nt function window at bar 0
   input wire logic nt_bar0_cfg_en,
   input wire logic [63:0] nt_bar0_base,
   input wire logic [RING_BITS*IDX_W-1:0] ring_map,
   // channel control
   input wire logic run_set,
   input wire logic msi_en,
   input wire logic intr_ack,
   output logic [dma_notify_pkg::STS_W-1:0] dma_channel_status_reg_ff,
   output logic msi_req_ff,
   output logic legacy_intr_ff,
   // descriptor stream
   input wire logic desc_valid,
   output logic desc_ready_ff,
   input wire logic desc_imm,
   input wire logic desc_last,
   input wire logic [63:0] desc_addr,
   input wire logic [31:0] desc_data,
   // memory writes toward the fabric
   output logic mw_valid,
   input wire logic mw_ready,
   output logic [63:0] mw_addr,
   output logic [31:0] mw_data,
   input wire logic wr_done,
   // writes from other agents
   input wire logic ext_wr_valid,
   input wire logic [63:0] ext_wr_addr,
   input wire logic [31:0] ext_wr_data,
   // peer partition side
   input wire logic [RING_BITS-1:0] peer_clear,
   input wire logic peer_msg_taken,
   output logic [RING_BITS-1:0] peer_ring_ff,
   output logic peer_intr_ff,
   output logic [31:0] peer_msg_ff,
   output logic peer_msg_full_ff
);
   localparam int SETUP_W = $clog2(SETUP_CYCLES + 1);

   initial begin
      if (RING_BITS < 1 || RING_BITS > 32)
         $error("RING_BITS must be 1..32");
      if (OUTST_W < 1) $error("OUTST_W must be positive");
      if (SETUP_CYCLES < 1) $error("SETUP_CYCLES must be positive");
   end

   // window decode shared by dma and external writers
   function automatic logic nt_hit(input logic en, input logic [63:0] addr,
                                   input logic [63:0] base,
                                   input logic [11:0] off);
      nt_hit = en && (addr[63:dma_notify_pkg::NT_WIN_BITS] ==
                      base[63:dma_notify_pkg::NT_WIN_BITS]) &&
               (addr[11:0] == off);
   endfunction : nt_hit

   dma_notify_pkg::dma_state_t state_ff, nxt_state;
   logic nxt_desc_ready;
   logic cur_imm_ff, nxt_cur_imm, cur_last_ff, nxt_cur_last;
   logic [63:0] cur_addr_ff, nxt_cur_addr;
   logic [31:0] cur_data_ff, nxt_cur_data;
   logic [OUTST_W-1:0] outst_ff, nxt_outst;
   logic [dma_notify_pkg::STS_W-1:0] nxt_sts;
   logic nxt_msi, nxt_legacy;
   logic buf_in_valid, buf_in_ready;
   logic dma_ring_hit, dma_msg_hit, ext_ring_hit, ext_msg_hit;
   logic int_wr, data_push, outst_full;
   logic ring_valid, msg_valid;
   logic [RING_BITS-1:0] ring_mask;
   logic [31:0] msg_data;
   logic nxt_cpl_valid, nxt_late;
   logic [2:0] nxt_cpl_status;
   logic [SETUP_W-1:0] setup_cnt_ff, nxt_setup_cnt;
   logic [63:0] nxt_cfg_base;

   // configuration answers and the setup watchdog
   always_comb begin
      nxt_cpl_valid = cfg_req_valid;
      nxt_cpl_status = cfg_cpl_status_ff;
      if (cfg_req_valid)
         nxt_cpl_status = unattached_mode ? dma_notify_pkg::CPL_RETRY
                                          : dma_notify_pkg::CPL_SUCCESS;
      nxt_setup_cnt = setup_cnt_ff;
      nxt_late = setup_late_ff;
      // the host is expected to leave unattached mode in time
      if (unattached_mode) begin
         if (setup_cnt_ff == SETUP_W'(SETUP_CYCLES))
            nxt_late = 1'b1;
         else
            nxt_setup_cnt = setup_cnt_ff + 1'b1;
      end
      if (bar_pair_64)
         nxt_cfg_base = {dma_bar1, dma_bar0[31:dma_notify_pkg::BAR_FLAG_BITS],
                         4'h0};
      else
         nxt_cfg_base = {32'h0, dma_bar0[31:dma_notify_pkg::BAR_FLAG_BITS],
                         4'h0};
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         cfg_cpl_valid_ff <= 1'b0;
         cfg_cpl_status_ff <= dma_notify_pkg::CPL_SUCCESS;
         setup_cnt_ff <= '0;
         setup_late_ff <= 1'b0;
         dma_cfg_base_ff <= '0;
      end else begin
         cfg_cpl_valid_ff <= nxt_cpl_valid;
         cfg_cpl_status_ff <= nxt_cpl_status;
         setup_cnt_ff <= nxt_setup_cnt;
         setup_late_ff <= nxt_late;
         dma_cfg_base_ff <= nxt_cfg_base;
      end
   end

   // immediate writes to the ring set or message offset of the nt window never leave the switch while nt_bar0_cfg_en is set
   assign dma_ring_hit = nt_hit(nt_bar0_cfg_en, cur_addr_ff, nt_bar0_base,
                                dma_notify_pkg::RING_SET_OFF);
   assign dma_msg_hit = nt_hit(nt_bar0_cfg_en, cur_addr_ff, nt_bar0_base,
                               dma_notify_pkg::MSG_OFF);
   assign ext_ring_hit = ext_wr_valid &&
      nt_hit(nt_bar0_cfg_en, ext_wr_addr, nt_bar0_base,
             dma_notify_pkg::RING_SET_OFF);
   assign ext_msg_hit = ext_wr_valid &&
      nt_hit(nt_bar0_cfg_en, ext_wr_addr, nt_bar0_base,
             dma_notify_pkg::MSG_OFF);
   assign outst_full = &outst_ff;

   always_comb begin
      nxt_state = state_ff;
      nxt_cur_imm = cur_imm_ff;
      nxt_cur_last = cur_last_ff;
      nxt_cur_addr = cur_addr_ff;
      nxt_cur_data = cur_data_ff;
      nxt_sts = dma_channel_status_reg_ff;
      nxt_msi = 1'b0;
      nxt_legacy = legacy_intr_ff && !intr_ack;
      buf_in_valid = 1'b0;
      int_wr = 1'b0;
      data_push = 1'b0;
      case (state_ff)
         dma_notify_pkg::ST_IDLE: begin
            if (run_set) begin
               nxt_sts = 3'h3;
               nxt_state = dma_notify_pkg::ST_FETCH;
            end
         end
         dma_notify_pkg::ST_FETCH: begin
            if (desc_valid && desc_ready_ff) begin
               nxt_cur_imm = desc_imm;
               nxt_cur_last = desc_last;
               nxt_cur_addr = desc_addr;
               nxt_cur_data = desc_data;
               nxt_state = desc_imm ? dma_notify_pkg::ST_IMM_WAIT
                                    : dma_notify_pkg::ST_ISSUE;
            end
         end
         dma_notify_pkg::ST_ISSUE: begin
            // a stalled receiver holds the channel here, no word is lost
            if (buf_in_ready && !outst_full) begin
               buf_in_valid = 1'b1;
               data_push = 1'b1;
               nxt_state = cur_last_ff ? dma_notify_pkg::ST_DRAIN
                                       : dma_notify_pkg::ST_FETCH;
            end
         end
         dma_notify_pkg::ST_IMM_WAIT: begin
            if (outst_ff == '0 && !mw_valid) begin
               if (dma_ring_hit || dma_msg_hit) begin
                  int_wr = 1'b1;
                  nxt_state = cur_last_ff ? dma_notify_pkg::ST_DRAIN
                                          : dma_notify_pkg::ST_FETCH;
               end else if (buf_in_ready) begin
                  buf_in_valid = 1'b1;
                  nxt_state = cur_last_ff ? dma_notify_pkg::ST_DRAIN
                                          : dma_notify_pkg::ST_FETCH;
               end
            end
         end
         dma_notify_pkg::ST_DRAIN: begin
            if (outst_ff == '0 && !mw_valid)
               nxt_state = dma_notify_pkg::ST_DONE;
         end
         dma_notify_pkg::ST_DONE: begin
            nxt_sts = 3'h4;
            nxt_msi = msi_en;
            nxt_legacy = !msi_en || nxt_legacy;
            nxt_state = dma_notify_pkg::ST_IDLE;
         end
         default: begin
            nxt_state = dma_notify_pkg::ST_IDLE;
         end
      endcase
      nxt_outst = outst_ff + OUTST_W'(data_push) - OUTST_W'(wr_done);
      nxt_desc_ready = (nxt_state == dma_notify_pkg::ST_FETCH) &&
                       !(desc_valid && desc_ready_ff);
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_ff <= dma_notify_pkg::ST_IDLE;
         desc_ready_ff <= 1'b0;
         cur_imm_ff <= 1'b0;
         cur_last_ff <= 1'b0;
         cur_addr_ff <= '0;
         cur_data_ff <= '0;
         outst_ff <= '0;
         dma_channel_status_reg_ff <= dma_notify_pkg::STS_RESET;
         msi_req_ff <= 1'b0;
         legacy_intr_ff <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         desc_ready_ff <= nxt_desc_ready;
         cur_imm_ff <= nxt_cur_imm;
         cur_last_ff <= nxt_cur_last;
         cur_addr_ff <= nxt_cur_addr;
         cur_data_ff <= nxt_cur_data;
         outst_ff <= nxt_outst;
         dma_channel_status_reg_ff <= nxt_sts;
         msi_req_ff <= nxt_msi;
         legacy_intr_ff <= nxt_legacy;
      end
   end

   // ring sets from both writers merge; dma wins a message collision
   always_comb begin
      ring_valid = (int_wr && dma_ring_hit) || ext_ring_hit;
      ring_mask = '0;
      if (int_wr && dma_ring_hit)
         ring_mask = cur_data_ff[RING_BITS-1:0];
      if (ext_ring_hit)
         ring_mask = ring_mask | ext_wr_data[RING_BITS-1:0];
      msg_valid = (int_wr && dma_msg_hit) || ext_msg_hit;
      msg_data = (int_wr && dma_msg_hit) ? cur_data_ff : ext_wr_data;
   end

   write_skid_buffer #(
      .WIDTH(96)
   ) u_wbuf (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .in_valid(buf_in_valid),
      .in_ready(buf_in_ready),
      .in_data({cur_addr_ff, cur_data_ff}),
      .out_valid(mw_valid),
      .out_ready(mw_ready),
      .out_data({mw_addr, mw_data})
   );

   ring_crossmap #(
      .RING_BITS(RING_BITS),
      .IDX_W(IDX_W)
   ) u_ring (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .set_valid(ring_valid),
      .set_mask(ring_mask),
      .ring_map(ring_map),
      .peer_clear(peer_clear),
      .msg_valid(msg_valid),
      .msg_data(msg_data),
      .peer_msg_taken(peer_msg_taken),
      .peer_ring_ff(peer_ring_ff),
      .peer_intr_ff(peer_intr_ff),
      .peer_msg_ff(peer_msg_ff),
      .peer_msg_full_ff(peer_msg_full_ff)
   );
endmodule : dma_doorbell_completion_notify

// [tb/dma_notify_checker.sv]
// concurrent checks on the ports of the dma doorbell notify block
`timescale 1ns/100ps
module dma_notify_checker #(
   parameter int RING_BITS = 32
) (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic unattached_mode,
   input wire logic cfg_req_valid,
   input wire logic cfg_cpl_valid_ff,
   input wire logic [2:0] cfg_cpl_status_ff,
   input wire logic run_set,
   input wire logic msi_en,
   input wire logic intr_ack,
   input wire logic [dma_notify_pkg::STS_W-1:0] dma_channel_status_reg_ff,
   input wire logic msi_req_ff,
   input wire logic legacy_intr_ff,
   input wire logic desc_valid,
   input wire logic desc_ready_ff,
   input wire logic mw_valid,
   input wire logic mw_ready,
   input wire logic [63:0] mw_addr,
   input wire logic [31:0] mw_data,
   input wire logic [RING_BITS-1:0] peer_ring_ff,
   input wire logic peer_intr_ff,
   input wire logic peer_msg_full_ff
);
   localparam int RN = dma_notify_pkg::STS_RUN_BIT;
   localparam int BS = dma_notify_pkg::STS_BUSY_BIT;
   localparam int DN = dma_notify_pkg::STS_DONE_BIT;
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   cfg_retry_a: assert property (cfg_req_valid && unattached_mode |=>
      cfg_cpl_valid_ff && cfg_cpl_status_ff == dma_notify_pkg::CPL_RETRY)
      else $error("retry completion missing");
   cfg_success_a: assert property (cfg_req_valid && !unattached_mode |=>
      cfg_cpl_valid_ff && cfg_cpl_status_ff == dma_notify_pkg::CPL_SUCCESS)
      else $error("success completion missing");
   run_start_a: assert property (run_set && !dma_channel_status_reg_ff[BS]
      |=> dma_channel_status_reg_ff[RN] && dma_channel_status_reg_ff[BS])
      else $error("run bit did not start the channel");
   ready_busy_a: assert property (desc_ready_ff |->
      dma_channel_status_reg_ff[BS]) else $error("ready while idle");
   mw_hold_a: assert property (mw_valid && !mw_ready |=> mw_valid &&
      $stable(mw_addr) && $stable(mw_data)) else $error("write dropped");
   done_intr_a: assert property ($rose(dma_channel_status_reg_ff[DN])
      |-> (msi_en ? msi_req_ff : legacy_intr_ff))
      else $error("no completion interrupt");
   legacy_hold_a: assert property (legacy_intr_ff && !intr_ack |=>
      legacy_intr_ff) else $error("legacy interrupt lost");
   peer_cause_a: assert property (peer_intr_ff |-> peer_msg_full_ff ||
      peer_ring_ff != $past(peer_ring_ff)) else $error("peer interrupt uncaused");
   desc_gap_a: assert property (desc_valid && desc_ready_ff |=>
      !desc_ready_ff) else $error("descriptor takes too close");
endmodule : dma_notify_checker

// [tb/fabric_sink_model.sv]
// far-side memory: takes posted writes, reports data completions late
`timescale 1ns/100ps
module fabric_sink_model (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic stall,
   input wire logic mw_valid,
   output logic mw_ready,
   input wire logic [63:0] mw_addr,
   input wire logic [31:0] mw_data,
   output logic wr_done
);
   logic [2:0] pipe_ff;
   int dones;
   logic [95:0] log_q[$];
   assign mw_ready = !stall;
   // completions trail acceptance by three cycles, like a distant target
   assign wr_done = pipe_ff[2];
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         pipe_ff <= 3'h0;
         dones <= 0;
      end else begin
         pipe_ff <= {pipe_ff[1:0], mw_valid && mw_ready};
         dones <= dones + int'(pipe_ff[2]);
         if (mw_valid && mw_ready)
            log_q.push_back({mw_addr, mw_data});
      end
   end
endmodule : fabric_sink_model

// [tb/tb_top.sv]
// self-checking bench for the dma doorbell completion notify block
`timescale 1ns/100ps
module tb_top;
   logic ref_clk, rst_n, unattached_mode, cfg_req_valid, cfg_cpl_valid_ff;
   logic [2:0] cfg_cpl_status_ff, dma_channel_status_reg_ff;
   logic setup_late_ff, bar_pair_64, nt_bar0_cfg_en, run_set, msi_en;
   logic [31:0] dma_bar0, dma_bar1, desc_data, mw_data, ext_wr_data;
   logic [63:0] dma_cfg_base_ff, nt_bar0_base, desc_addr, mw_addr, ext_wr_addr;
   logic [159:0] ring_map;
   logic intr_ack, msi_req_ff, legacy_intr_ff, desc_valid, desc_ready_ff;
   logic desc_imm, desc_last, mw_valid, mw_ready, wr_done, ext_wr_valid;
   logic [31:0] peer_clear, peer_ring_ff, peer_msg_ff;
   logic peer_msg_taken, peer_intr_ff, peer_msg_full_ff;
   logic stall, stall_en, hold_stall;
   int seed, fails, checks;
   logic [31:0] d;

   dma_doorbell_completion_notify #(.SETUP_CYCLES(50)) uut (.ref_clk, .rst_n,
      .unattached_mode, .cfg_req_valid, .cfg_cpl_valid_ff, .cfg_cpl_status_ff,
      .setup_late_ff, .bar_pair_64, .dma_bar0, .dma_bar1, .dma_cfg_base_ff,
      .nt_bar0_cfg_en, .nt_bar0_base, .ring_map, .run_set, .msi_en, .intr_ack,
      .dma_channel_status_reg_ff, .msi_req_ff, .legacy_intr_ff, .desc_valid,
      .desc_ready_ff, .desc_imm, .desc_last, .desc_addr, .desc_data, .mw_valid,
      .mw_ready, .mw_addr, .mw_data, .wr_done, .ext_wr_valid, .ext_wr_addr,
      .ext_wr_data, .peer_clear, .peer_msg_taken, .peer_ring_ff, .peer_intr_ff,
      .peer_msg_ff, .peer_msg_full_ff);
   fabric_sink_model fab (.ref_clk, .rst_n, .stall, .mw_valid, .mw_ready,
      .mw_addr, .mw_data, .wr_done);

   initial begin
      ref_clk = 1'b0;
      forever #12.5 ref_clk = ~ref_clk;
   end
   always @(negedge ref_clk) stall = hold_stall || (stall_en && $random(seed) % 2);

   task automatic check(input logic [95:0] seen, input logic [95:0] exp);
      checks++;
      if (seen !== exp) begin
         fails++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check
   task automatic wrap_up();
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : wrap_up
   task automatic tick_until(ref logic s, input int lim);
      for (int n = 0; n < lim && s !== 1'b1; n++) @(negedge ref_clk);
      if (s !== 1'b1) begin
         fails++;
         wrap_up();
      end
   endtask : tick_until
   function automatic logic [63:0] bar_base(logic p, logic [31:0] b0, b1);
      return {p ? b1 : 32'h0, b0[31:4], 4'h0};
   endfunction : bar_base
   function automatic logic [31:0] map_bit(logic [4:0] k);
      return 32'h1 << (5'h1F - k);
   endfunction : map_bit
   task automatic pulse(ref logic s);
      s = 1'b1;
      @(negedge ref_clk);
      s = 1'b0;
   endtask : pulse
   task automatic cfg_req(input logic ua);
      unattached_mode = ua;
      pulse(cfg_req_valid);
      check(cfg_cpl_valid_ff, 1'b1);
      check(cfg_cpl_status_ff, ua ? 3'h2 : 3'h0);
   endtask : cfg_req
   task automatic ext_wr(input logic [11:0] off, input logic [31:0] v);
      ext_wr_addr = nt_bar0_base + 64'(off);
      ext_wr_data = v;
      pulse(ext_wr_valid);
      tick_until(peer_intr_ff, 8);
   endtask : ext_wr
   task automatic send_desc(input logic im, input logic [63:0] a);
      desc_valid = 1'b1;
      desc_imm = im;
      desc_last = im;
      desc_addr = a;
      desc_data = d;
      tick_until(desc_ready_ff, 300);
      @(negedge ref_clk);
   endtask : send_desc
   task automatic run_list(input int n, input logic msi);
      logic [95:0] exp_q[$];
      int base;
      logic [4:0] k;
      msi_en = msi;
      hold_stall = msi;
      fab.log_q.delete();
      base = fab.dones;
      pulse(run_set);
      for (int i = 0; i < n; i++) begin
         if (i == 3) hold_stall = 1'b0;
         d = $random(seed);
         exp_q.push_back({{$random(seed), $random(seed)}, d});
         send_desc(1'b0, exp_q[i][95:32]);
      end
      k = 5'($random(seed));
      // the legacy run ends on the message register instead of the ring
      d = msi ? 32'h1 << k : $random(seed);
      send_desc(1'b1, nt_bar0_base + 64'(msi ? dma_notify_pkg::RING_SET_OFF
                                             : dma_notify_pkg::MSG_OFF));
      desc_valid = 1'b0;
      tick_until(peer_intr_ff, 400);
      check(96'(fab.dones - base), 96'(n));
      if (msi) check(peer_ring_ff, map_bit(k));
      else check({peer_msg_full_ff, peer_msg_ff}, {1'b1, d});
      if (msi) tick_until(msi_req_ff, 50);
      else tick_until(legacy_intr_ff, 50);
      check(dma_channel_status_reg_ff, 3'h4);
      check(96'(fab.log_q.size()), 96'(n));
      foreach (exp_q[i]) check(fab.log_q[i], exp_q[i]);
      pulse(intr_ack);
      @(negedge ref_clk);
      check(legacy_intr_ff, 1'b0);
      peer_clear = '1;
      @(negedge ref_clk);
      peer_clear = '0;
   endtask : run_list

   initial begin
      {cfg_req_valid, bar_pair_64, run_set, msi_en, intr_ack, desc_valid} = '0;
      {desc_imm, desc_last, ext_wr_valid, peer_msg_taken, stall_en} = '0;
      {dma_bar0, dma_bar1, desc_addr, desc_data, ext_wr_addr, ext_wr_data} = '0;
      {peer_clear, hold_stall, fails, checks, d} = '0;
      seed = 20;
      nt_bar0_cfg_en = 1'b1;
      nt_bar0_base = 64'hF000_0000_4000_0000;
      for (int i = 0; i < 32; i++) ring_map[i*5 +: 5] = 5'(31 - i);
      unattached_mode = 1'b1;
      rst_n = 1'b0;
      repeat (2) @(negedge ref_clk);
      rst_n = 1'b1;
      check(dma_channel_status_reg_ff, dma_notify_pkg::STS_RESET);
      cfg_req(1'b1);
      cfg_req(1'b0);
      check(setup_late_ff, 1'b0);
      for (int p = 0; p < 2; p++) begin
         bar_pair_64 = p[0];
         dma_bar0 = p[0] ? 32'hFFFF_FFFF : $random(seed);
         dma_bar1 = $random(seed);
         repeat (2) @(negedge ref_clk);
         check(dma_cfg_base_ff, bar_base(p[0], dma_bar0, dma_bar1));
      end
      // with the window closed a ring write must not reach the peer
      nt_bar0_cfg_en = 1'b0;
      ext_wr_addr = nt_bar0_base + 64'(dma_notify_pkg::RING_SET_OFF);
      ext_wr_data = '1;
      pulse(ext_wr_valid);
      check({peer_intr_ff, peer_ring_ff}, '0);
      nt_bar0_cfg_en = 1'b1;
      for (int j = 0; j < 4; j++) begin
         d = 32'h1 << j * 9;
         ext_wr(dma_notify_pkg::RING_SET_OFF, d);
         check(peer_ring_ff, map_bit(5'(j * 9)));
         peer_clear = map_bit(5'(j * 9));
         @(negedge ref_clk);
         peer_clear = '0;
         check(peer_ring_ff, '0);
         d = $random(seed);
         ext_wr(dma_notify_pkg::MSG_OFF, d);
         check({peer_msg_full_ff, peer_msg_ff}, {1'b1, d});
         pulse(peer_msg_taken);
         check(peer_msg_full_ff, 1'b0);
      end
      run_list(5, 1'b1);
      stall_en = 1'b1;
      run_list(3, 1'b0);
      unattached_mode = 1'b1;
      repeat (60) @(negedge ref_clk);
      check(setup_late_ff, 1'b1);
      wrap_up();
   end
endmodule : tb_top

bind dma_doorbell_completion_notify dma_notify_checker #(
   .RING_BITS(RING_BITS)) chk (.ref_clk, .rst_n, .unattached_mode,
   .cfg_req_valid, .cfg_cpl_valid_ff, .cfg_cpl_status_ff, .run_set, .msi_en,
   .intr_ack, .dma_channel_status_reg_ff, .msi_req_ff, .legacy_intr_ff,
   .desc_valid, .desc_ready_ff, .mw_valid, .mw_ready, .mw_addr, .mw_data,
   .peer_ring_ff, .peer_intr_ff, .peer_msg_full_ff);
